//--- cdd_pkg.sv
// Purpose: shared constants and types of the converter digital diagnostics unit
// Assumes: apb register map with one 32-bit word per register
// Notes:   byte offsets and field positions live here only; dac setup and flag reset values sit in cdd_diag
package cdd_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] KEY_OFS         = 8'h00;
   localparam logic [7:0] DAC_SETUP_OFS   = 8'h04;
   localparam logic [7:0] DIAG_SETUP_OFS  = 8'h08;
   localparam logic [7:0] GEN_ONE_OFS     = 8'h0c;
   localparam logic [7:0] GEN_TWO_OFS     = 8'h10;
   localparam logic [7:0] DIG_FLAGS_OFS   = 8'h14;
   localparam logic [7:0] ANA_FLAGS_OFS   = 8'h18;
   localparam logic [7:0] STATUS_OFS      = 8'h1c;
   localparam logic [7:0] FREQ_CNT_OFS    = 8'h20;
   localparam logic [7:0] RB_SELECT_OFS   = 8'h24;
   localparam logic [7:0] NOP_OFS         = 8'h28;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int RANGE_LSB      = 0;   // output range, bits[3:0]
   localparam int RANGE_W        = 4;
   localparam int INT_EN_BIT     = 8;
   localparam int CRC_EN_BIT     = 0;
   localparam int FREQ_EN_BIT    = 1;
   localparam int OSC_EN_BIT     = 0;
   localparam int TRIP_LSB       = 1;
   localparam int TRIP_W         = 2;
   localparam int CMP_EN_BIT     = 0;
   localparam int DIG_SUM_BIT    = 0;
   localparam int ANA_SUM_BIT    = 1;
   localparam int FAULT_STAT_BIT = 2;
   localparam int RB_SEL_W       = 6;

   // ----------------------------------------------------------------
   // reset values and codes
   // ----------------------------------------------------------------
   localparam logic [31:0] DIAG_SETUP_RST  = 32'h0000_0003;  // crc and freq counter on
   localparam logic [31:0] GEN_ONE_RST     = 32'h0000_0001;  // osc halt signalling on
   localparam logic [31:0] GEN_TWO_RST     = 32'h0000_0000;  // supply comparators off
   localparam logic [23:0] OSC_HALT_CODE   = 24'h07dead;
   localparam logic [15:0] REFRESH_KEY     = 16'h3c5a;      // arbitrary value
   localparam logic [7:0]  CRC_POLY        = 8'h07;
   localparam logic [7:0]  CRC_INIT        = 8'hff;
   localparam int          FREQ_DIV        = 10000;          // oscillator cycles per tick
   localparam int          SPI_WORD_W      = 24;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic slew_busy;
      logic cal_not_loaded;
      logic osc_stop;
      logic invalid_access;
      logic cal_crc_err;
      logic reset_seen;
   } dig_flags_type;

   typedef struct packed {
      logic internal_analog_supply_node;
      logic regulator;
      logic reference_output_node;
      logic reference_input_node;
      logic dcdc_temp;
      logic main_temp;
   } ana_flags_type;

   // w1 update applies to these digital bits only
   localparam logic [5:0] DIG_W1_MASK = 6'h0f;

   typedef enum logic [1:0] {
      CDD_IDLE  = 2'b00,
      CDD_READ  = 2'b01,
      CDD_CHECK = 2'b11
   } refresh_state_type;

endpackage : cdd_pkg

//--- cdd_diag.sv
// Purpose: digital diagnostics: calibration crc refresh, frequency monitor,
//          oscillator halt readback code, sticky diagnostic flags, fault pin
// Assumes: apb slave on mclk_i, calibration memory read combinationally,
//          comparator and link pins asynchronous to mclk_i
// Notes:   zero-wait apb slave; link shifts 24-bit words msb first
`timescale 1ns/10ps

module cdd_diag #(
   parameter int FREQ_DIV  = cdd_pkg::FREQ_DIV,
   parameter int CAL_WORDS = 16,
   parameter int CAL_AW    = 4
) (
   // clock and reset
   input  wire logic                mclk_i,
   input  wire logic                rstn_i,
   // apb slave
   input  wire logic                psel_i,
   input  wire logic                penable_i,
   input  wire logic                pwrite_i,
   input  wire logic [7:0]          paddr_i,
   input  wire logic [31:0]         pwdata_i,
   output logic      [31:0]         prdata_o,
   output logic                     pready_o,
   output logic                     pslverr_o,
   // calibration memory
   output logic      [CAL_AW-1:0]   cal_rd_addr_o,
   input  wire logic [15:0]         cal_rd_data_i,
   input  wire logic [7:0]          cal_ref_crc_i,
   // comparators and analog status (asynchronous)
   input  wire logic                osc_halt_i,
   input  wire logic [1:0]          die_temp_over_i,
   input  wire logic [3:0]          supply_out_of_range_i,
   input  wire logic                slew_active_i,
   output logic      [1:0]          temp_trip_sel_o,
   output logic                     supply_cmp_enable_o,
   output logic                     ref_buffer_enable_o,
   // readback link
   input  wire logic                sclk_i,
   input  wire logic                cs_n_i,
   output logic                     sdo_o,
   output logic                     sdo_oe_o,
   // fault pin, open drain
   output logic                     fault_n_o,
   output logic                     fault_n_oe_o
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [31:0]                  dac_setup_reg, diag_setup_reg, gen_one_reg, gen_two_reg;
   logic [cdd_pkg::RB_SEL_W-1:0] rb_sel_reg;
   cdd_pkg::dig_flags_type       digital_diag_flags_reg;
   cdd_pkg::ana_flags_type       analog_diag_flags_reg;
   logic [15:0]                  freq_counter_reg;
   logic [$clog2(FREQ_DIV)-1:0]  prescale_reg;
   cdd_pkg::refresh_state_type   state_reg;
   logic [CAL_AW-1:0]            addr_reg;
   logic [7:0]                   crc_reg;
   logic                         crc_fault_reg, fault_oe_reg;
   logic [1:0]                   osc_sync_reg, sclk_sync_reg, cs_sync_reg;
   logic [3:0]                   temp_sync_reg;
   logic [7:0]                   sup_sync_reg;
   logic                         sclk_last_reg, cs_last_reg;
   logic [cdd_pkg::SPI_WORD_W-1:0] shift_reg;

   logic        wr_access, wr_allowed, busy, start_refresh, check_done, crc_mismatch;
   logic        mapped, digital_summary_bit, analog_summary_bit, supply_en;
   logic        freq_counter_enable, osc_halt_signal_enable;
   logic [5:0]  dig_w1, ana_w1, dig_evt, dig_cur, ana_live;
   logic [31:0] status_word, rb_word;
   logic [23:0] link_word;

   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [15:0] d);
      logic [7:0] r;
      logic       fb;
      r = c;
      for (int i = 15; i >= 0; i--) begin
         fb = r[7] ^ d[i];
         r  = {r[6:0], 1'b0} ^ (fb ? cdd_pkg::CRC_POLY : 8'h00);
      end
      return r;
   endfunction : crc_step

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   assign pready_o   = 1'b1;
   assign pslverr_o  = psel_i && penable_i && !mapped;
   assign mapped     = (paddr_i <= cdd_pkg::NOP_OFS) && (paddr_i[1:0] == 2'b00);
   assign wr_access  = psel_i && penable_i && pwrite_i && mapped;
   assign busy       = state_reg != cdd_pkg::CDD_IDLE;
   assign wr_allowed = wr_access && (!busy || paddr_i == cdd_pkg::RB_SELECT_OFS
                       || paddr_i == cdd_pkg::NOP_OFS);

   assign start_refresh = wr_allowed && ((paddr_i == cdd_pkg::KEY_OFS
          && pwdata_i[15:0] == cdd_pkg::REFRESH_KEY)
          || (paddr_i == cdd_pkg::DAC_SETUP_OFS
          && pwdata_i[cdd_pkg::RANGE_LSB +: cdd_pkg::RANGE_W]
             != dac_setup_reg[cdd_pkg::RANGE_LSB +: cdd_pkg::RANGE_W]));

   assign freq_counter_enable    = diag_setup_reg[cdd_pkg::FREQ_EN_BIT];
   assign osc_halt_signal_enable = gen_one_reg[cdd_pkg::OSC_EN_BIT];
   assign supply_en              = gen_two_reg[cdd_pkg::CMP_EN_BIT];
   assign temp_trip_sel_o        = gen_one_reg[cdd_pkg::TRIP_LSB +: cdd_pkg::TRIP_W];
   assign supply_cmp_enable_o    = supply_en;
   assign ref_buffer_enable_o    = dac_setup_reg[cdd_pkg::INT_EN_BIT];

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dac_setup_reg  <= 32'h0000_0000;
         diag_setup_reg <= cdd_pkg::DIAG_SETUP_RST;
         gen_one_reg    <= cdd_pkg::GEN_ONE_RST;
         gen_two_reg    <= cdd_pkg::GEN_TWO_RST;
         rb_sel_reg     <= '0;
      end else if (wr_allowed) begin
         case (paddr_i)
            cdd_pkg::DAC_SETUP_OFS:  dac_setup_reg  <= pwdata_i;
            cdd_pkg::DIAG_SETUP_OFS: diag_setup_reg <= pwdata_i;
            cdd_pkg::GEN_ONE_OFS:    gen_one_reg    <= pwdata_i;
            cdd_pkg::GEN_TWO_OFS:    gen_two_reg    <= pwdata_i;
            cdd_pkg::RB_SELECT_OFS:  rb_sel_reg     <= pwdata_i[cdd_pkg::RB_SEL_W-1:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // calibration refresh, crc and frequency monitor
   // ----------------------------------------------------------------
   assign cal_rd_addr_o = addr_reg;
   assign check_done    = state_reg == cdd_pkg::CDD_CHECK;
   assign crc_mismatch  = crc_reg != cal_ref_crc_i;

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state_reg     <= cdd_pkg::CDD_IDLE;
         addr_reg      <= '0;
         crc_reg       <= cdd_pkg::CRC_INIT;
         crc_fault_reg <= 1'b0;
      end else begin
         case (state_reg)
            cdd_pkg::CDD_IDLE: begin
               if (start_refresh) begin
                  state_reg <= cdd_pkg::CDD_READ;
                  addr_reg  <= '0;
                  crc_reg   <= cdd_pkg::CRC_INIT;
               end
            end
            cdd_pkg::CDD_READ: begin
               crc_reg  <= crc_step(crc_reg, cal_rd_data_i);
               addr_reg <= addr_reg + 1'b1;
               if (addr_reg == CAL_AW'(CAL_WORDS - 1)) begin
                  state_reg <= cdd_pkg::CDD_CHECK;
               end
            end
            cdd_pkg::CDD_CHECK: begin
               // a disabled check reports a clean result
               crc_fault_reg <= crc_mismatch && diag_setup_reg[cdd_pkg::CRC_EN_BIT];
               state_reg     <= cdd_pkg::CDD_IDLE;
            end
            default: state_reg <= cdd_pkg::CDD_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prescale_reg     <= '0;
         freq_counter_reg <= 16'h0000;
      end else if (freq_counter_enable) begin
         if (prescale_reg == $bits(prescale_reg)'(FREQ_DIV - 1)) begin
            prescale_reg     <= '0;
            freq_counter_reg <= freq_counter_reg + 16'h0001;
         end else begin
            prescale_reg <= prescale_reg + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         osc_sync_reg  <= 2'b00;
         temp_sync_reg <= 4'h0;
         sup_sync_reg  <= 8'h00;
         sclk_sync_reg <= 2'b00;
         cs_sync_reg   <= 2'b11;
      end else begin
         osc_sync_reg  <= {osc_sync_reg[0], osc_halt_i};
         temp_sync_reg <= {temp_sync_reg[1:0], die_temp_over_i};
         sup_sync_reg  <= {sup_sync_reg[3:0], supply_out_of_range_i};
         sclk_sync_reg <= {sclk_sync_reg[0], sclk_i};
         cs_sync_reg   <= {cs_sync_reg[0], cs_n_i};
      end
   end

   // ----------------------------------------------------------------
   // sticky flags; slew busy follows its input live, cal not loaded is set by a refresh start and cleared by its check
   // ----------------------------------------------------------------
   assign dig_w1 = (wr_allowed && paddr_i == cdd_pkg::DIG_FLAGS_OFS)
                   ? (pwdata_i[5:0] & cdd_pkg::DIG_W1_MASK) : 6'h00;
   assign ana_w1 = (wr_allowed && paddr_i == cdd_pkg::ANA_FLAGS_OFS)
                   ? pwdata_i[5:0] : 6'h00;
   // order: slew, not loaded, osc stop, invalid access, crc error, reset seen
   assign dig_evt = {1'b0, 1'b0, osc_sync_reg[1], wr_access && !wr_allowed,
                     check_done && crc_mismatch && diag_setup_reg[cdd_pkg::CRC_EN_BIT],
                     1'b0};
   assign dig_cur = {1'b0, 1'b0, osc_sync_reg[1], 1'b0, crc_fault_reg, 1'b0};
   // supply comparator results ignored while the supply comparators are off
   assign ana_live = {sup_sync_reg[7:4] & {4{supply_en}}, temp_sync_reg[3:2]};

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         digital_diag_flags_reg <= cdd_pkg::dig_flags_type'(6'h01);
      end else begin
         // set wins over a same-cycle w1 update
         for (int i = 0; i < 4; i++) begin
            digital_diag_flags_reg[i] <= (dig_w1[i] ? dig_cur[i]
                                          : digital_diag_flags_reg[i]) | dig_evt[i];
         end
         if (start_refresh) begin
            digital_diag_flags_reg.cal_not_loaded <= 1'b1;
         end else if (check_done) begin
            digital_diag_flags_reg.cal_not_loaded <= 1'b0;
         end
         digital_diag_flags_reg.slew_busy <= slew_active_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         analog_diag_flags_reg <= '0;
      end else begin
         analog_diag_flags_reg <= (analog_diag_flags_reg & ~ana_w1) | ana_live;
      end
   end

   assign digital_summary_bit = |digital_diag_flags_reg[4:0];
   assign analog_summary_bit  = |analog_diag_flags_reg;
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[cdd_pkg::DIG_SUM_BIT]    = digital_summary_bit;
      status_word[cdd_pkg::ANA_SUM_BIT]    = analog_summary_bit;
      status_word[cdd_pkg::FAULT_STAT_BIT] = fault_oe_reg;
   end

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         fault_oe_reg <= 1'b0;
      end else begin
         fault_oe_reg <= digital_diag_flags_reg.cal_crc_err
                      || digital_diag_flags_reg.invalid_access
                      || digital_diag_flags_reg.osc_stop
                      || analog_summary_bit;
      end
   end
   assign fault_n_o    = 1'b0;
   assign fault_n_oe_o = fault_oe_reg;

   // ----------------------------------------------------------------
   // register read and readback link
   // ----------------------------------------------------------------
   function automatic logic [31:0] read_word(input logic [7:0] a);
      case (a)
         cdd_pkg::DAC_SETUP_OFS:  return dac_setup_reg;
         cdd_pkg::DIAG_SETUP_OFS: return diag_setup_reg;
         cdd_pkg::GEN_ONE_OFS:    return gen_one_reg;
         cdd_pkg::GEN_TWO_OFS:    return gen_two_reg;
         cdd_pkg::DIG_FLAGS_OFS:  return {26'h0, digital_diag_flags_reg};
         cdd_pkg::ANA_FLAGS_OFS:  return {26'h0, analog_diag_flags_reg};
         cdd_pkg::STATUS_OFS:     return status_word;
         cdd_pkg::FREQ_CNT_OFS:   return {16'h0000, freq_counter_reg};
         cdd_pkg::RB_SELECT_OFS:  return {26'h0, rb_sel_reg};
         default:                 return 32'h0000_0000;
      endcase
   endfunction : read_word

   // captured in the setup phase so data comes from a flop at zero wait
   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (psel_i && !penable_i) begin
         prdata_o <= read_word(paddr_i);
      end
   end

   // a real halt stops this clock too; the halt input stands in for its detector
   always_comb rb_word = read_word({rb_sel_reg, 2'b00});
   assign link_word = (osc_sync_reg[1] && osc_halt_signal_enable)
                      ? cdd_pkg::OSC_HALT_CODE
                      : {8'h00, rb_word[15:0]};

   always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sclk_last_reg <= 1'b0;
         cs_last_reg   <= 1'b1;
         shift_reg     <= '0;
         sdo_oe_o      <= 1'b0;
      end else begin
         sclk_last_reg <= sclk_sync_reg[1];
         cs_last_reg   <= cs_sync_reg[1];
         sdo_oe_o      <= !cs_sync_reg[1];
         if (cs_last_reg && !cs_sync_reg[1]) begin
            shift_reg <= link_word;
         end else if (!cs_sync_reg[1] && sclk_last_reg && !sclk_sync_reg[1]) begin
            shift_reg <= {shift_reg[cdd_pkg::SPI_WORD_W-2:0], 1'b0};
         end
      end
   end
   assign sdo_o = shift_reg[cdd_pkg::SPI_WORD_W-1];

endmodule : cdd_diag

//--- cdd_diag_properties.sv
// Purpose: port assertions of the diagnostics unit
// Assumes: bound to the design top; sees its ports only
// Notes:   sync delays give the repetition counts some slack
`timescale 1ns/10ps
module cdd_diag_properties (
   input wire logic        mclk_i, rstn_i, psel_i, penable_i, pwrite_i,
   input wire logic        pslverr_o, cs_n_i, sdo_oe_o, fault_n_o, fault_n_oe_o,
   input wire logic        supply_cmp_enable_o, ref_buffer_enable_o,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic [1:0]  die_temp_over_i, temp_trip_sel_o);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rstn_i);
   wire acc = psel_i && penable_i;
   unmapped_err_a: assert property (acc && paddr_i > 8'h28 |-> pslverr_o && prdata_o == 32'h0)
      else $error("unmapped access not refused");
   mapped_ok_a: assert property (acc && paddr_i <= 8'h28 && paddr_i[1:0] == 2'b00 |-> !pslverr_o)
      else $error("mapped access refused");
   reset_off_a: assert property ($rose(rstn_i) |-> !supply_cmp_enable_o && !ref_buffer_enable_o)
      else $error("comparator or buffer enabled after reset");
   fault_level_a: assert property (fault_n_oe_o |-> !fault_n_o)
      else $error("fault pin driven high");
   temp_fault_a: assert property ((die_temp_over_i != 2'b00) [*5] |=> fault_n_oe_o)
      else $error("over temperature without fault pin");
   link_idle_a: assert property (cs_n_i [*4] |=> !sdo_oe_o)
      else $error("data line driven outside frame");
   link_drive_a: assert property (!cs_n_i [*4] |=> sdo_oe_o)
      else $error("data line not driven in frame");
   fault_clear_a: assert property ($fell(fault_n_oe_o) |-> $past(pwrite_i, 2) || $past(pwrite_i, 3))
      else $error("fault released without a write");
endmodule : cdd_diag_properties

//--- cdd_spi_host.sv
// Purpose: behavioural host on the readback link
// Assumes: 200 ns link period, sampling on the rising link clock
// Notes:   short high phase leaves the design time to shift after the fall
`timescale 1ns/10ps
module cdd_spi_host (
   output logic            sclk_o,
   output logic            cs_n_o,
   input  wire logic       sdo_i,
   input  wire logic       sdo_oe_i);
   logic last = 1'b0;
   // a released line shows the inverse of its last bit, never a stale value
   wire line = sdo_oe_i ? sdo_i : ~last;
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
   end
   task automatic frame(output logic [23:0] w);
      cs_n_o = 1'b0;
      #300;
      for (int i = 23; i >= 0; i--) begin
         sclk_o = 1'b1;
         w[i] = line;
         last = line;
         #50 sclk_o = 1'b0;
         #150;
      end
      cs_n_o = 1'b1;
      #400;
   endtask : frame
endmodule : cdd_spi_host

//--- tb_converter_digital_diagnostics.sv
// Purpose: self-checking bench of the diagnostics unit
// Assumes: frequency divider shortened to 10
// Notes:   waits after a refresh outlast its busy time
`timescale 1ns/10ps
module tb_converter_digital_diagnostics;
   logic mclk_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, osc_halt_i = 0;
   logic slew_active_i = 0, pready_o, pslverr_o, sclk_i, cs_n_i, sdo_o, sdo_oe_o, err;
   logic fault_n_o, fault_n_oe_o, supply_cmp_enable_o, ref_buffer_enable_o;
   logic [7:0]  paddr_i = 0, cal_ref_crc_i = 0, good;
   logic [31:0] pwdata_i = 0, prdata_o, rd, cnt;
   logic [3:0]  cal_rd_addr_o, supply_out_of_range_i = 0;
   logic [1:0]  die_temp_over_i = 0, temp_trip_sel_o;
   logic [23:0] word;
   logic [72:0] rows [12] = '{{1'b0, 8'h08, 32'h0, 32'h3}, {1'b0, 8'h0c, 32'h0, 32'h1},
      {1'b0, 8'h10, 32'h0, 32'h0}, {1'b0, 8'h14, 32'h0, 32'h1}, {1'b0, 8'h1c, 32'h0, 32'h1},
      {1'b1, 8'h14, 32'h1, 32'h0}, {1'b0, 8'h14, 32'h0, 32'h0},
      {1'b1, 8'h1c, 32'hffff_ffff, 32'h0},
      {1'b0, 8'h1c, 32'h0, 32'h0}, {1'b1, 8'h10, 32'h1, 32'h0}, {1'b0, 8'h10, 32'h0, 32'h1},
      {1'b0, 8'h2c, 32'h0, 32'h0}};
   int errors = 0, n_compared = 0, n;
   wire logic [15:0] cal_rd_data_i = {12'h000, cal_rd_addr_o} * 16'h1357;
   always #12.5 mclk_i = ~mclk_i;
   cdd_diag #(.FREQ_DIV(10)) DUT (.*);
   cdd_spi_host host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o));
   function automatic logic [7:0] crc8();
      logic [7:0]  c = cdd_pkg::CRC_INIT;
      logic [15:0] d;
      for (int k = 0; k < 16; k++) begin
         d = {12'h000, 4'(k)} * 16'h1357;
         for (int b = 15; b >= 0; b--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[b]) ? cdd_pkg::CRC_POLY : 8'h00);
      end
      return c;
   endfunction : crc8
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task end_sim;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
      @(posedge mclk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin @(posedge mclk_i); n++; end while (pready_o !== 1'b1 && n < 20);
      if (n >= 20) begin errors++; end_sim(); end
      rd = prdata_o;
      err = pslverr_o;
      {psel_i, penable_i} <= 2'b00;
      #1;
   endtask : apb
   task rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rdchk
   initial begin
      good = crc8();
      repeat (3) @(posedge mclk_i);
      rstn_i <= 1'b1;
      foreach (rows[i]) begin
         apb(rows[i][72], rows[i][71:64], rows[i][63:32]);
         if (!rows[i][72]) check(rd, rows[i][31:0]);
      end
      check({31'h0, err}, 32'h1);
      check({31'h0, supply_cmp_enable_o}, 32'h1);
      cal_ref_crc_i <= good;
      apb(1'b1, 8'h00, {16'h0, cdd_pkg::REFRESH_KEY});
      rdchk(8'h14, 32'h10);
      apb(1'b1, 8'h0c, 32'h6);
      repeat (30) @(posedge mclk_i);
      rdchk(8'h14, 32'h04);
      rdchk(8'h0c, 32'h1);
      check({31'h0, fault_n_oe_o}, 32'h1);
      apb(1'b1, 8'h14, 32'h3f);
      rdchk(8'h14, 32'h0);
      cal_ref_crc_i <= good ^ 8'h01;
      apb(1'b1, 8'h08, 32'h2);
      apb(1'b1, 8'h04, 32'h105);
      repeat (30) @(posedge mclk_i);
      rdchk(8'h14, 32'h0);
      check({31'h0, ref_buffer_enable_o}, 32'h1);
      apb(1'b1, 8'h08, 32'h3);
      apb(1'b1, 8'h00, {16'h0, cdd_pkg::REFRESH_KEY});
      repeat (30) @(posedge mclk_i);
      rdchk(8'h14, 32'h2);
      rdchk(8'h1c, 32'h5);
      apb(1'b1, 8'h0c, 32'h7);
      check({30'h0, temp_trip_sel_o}, 32'h3);
      {die_temp_over_i, supply_out_of_range_i} <= 6'h12;
      repeat (6) @(posedge mclk_i);
      rdchk(8'h18, 32'h9);
      rdchk(8'h1c, 32'h7);
      {die_temp_over_i, supply_out_of_range_i} <= 6'h00;
      repeat (4) @(posedge mclk_i);
      apb(1'b1, 8'h18, 32'h3f);
      rdchk(8'h18, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      cnt = rd;
      repeat (97) @(posedge mclk_i);
      apb(1'b0, 8'h20, 32'h0);
      check((rd - cnt) & 32'hffff, 32'd10);
      apb(1'b1, 8'h08, 32'h1);
      apb(1'b0, 8'h20, 32'h0);
      cnt = rd;
      repeat (50) @(posedge mclk_i);
      rdchk(8'h20, cnt);
      apb(1'b1, 8'h24, 32'h2);
      host.frame(word);
      check({8'h0, word}, 32'h1);
      osc_halt_i <= 1'b1;
      repeat (4) @(posedge mclk_i);
      host.frame(word);
      check({8'h0, word}, {8'h0, cdd_pkg::OSC_HALT_CODE});
      rdchk(8'h14, 32'h0a);
      apb(1'b1, 8'h0c, 32'h6);
      host.frame(word);
      check({8'h0, word}, 32'h1);
      osc_halt_i <= 1'b0;
      rstn_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      rstn_i <= 1'b1;
      rdchk(8'h14, 32'h1);
      rdchk(8'h0c, 32'h1);
      apb(1'b1, 8'h14, 32'h1);
      slew_active_i <= 1'b1;
      rdchk(8'h14, 32'h20);
      rdchk(8'h1c, 32'h0);
      slew_active_i <= 1'b0;
      rdchk(8'h14, 32'h0);
      end_sim();
   end
endmodule : tb_converter_digital_diagnostics
bind cdd_diag cdd_diag_properties chk (.*);
